/* File: core/fgp_regs.svh */
// Purpose: Offsets, field positions and reset values of the four pin port
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: Only the low eight address bits are decoded
`ifndef FGP_REGS_SVH
`define FGP_REGS_SVH

`define FGP_OFF_PIN_LEVEL 8'h00
`define FGP_OFF_DIRECTION 8'h04
`define FGP_OFF_LATCH 8'h08
`define FGP_OFF_ANALOG 8'h0c
`define FGP_OFF_PULLUP 8'h10
`define FGP_OFF_OPEN_DRAIN 8'h14
`define FGP_OFF_SLEW 8'h18
`define FGP_OFF_THRESHOLD 8'h1c

`define FGP_BIDIR_W 3
`define FGP_PIN_W 4
`define FGP_INPUT_ONLY_BIT 3

`define FGP_RST_DIRECTION 3'h7
`define FGP_RST_ANALOG 3'h7
`define FGP_RST_PULLUP 4'hf
`define FGP_RST_OPEN_DRAIN 3'h0
`define FGP_RST_SLEW 3'h7
`define FGP_RST_THRESHOLD 4'hf
`define FGP_DIR_BIT3_VALUE 1'h1

`endif

/* File: core/fgp_pkg.sv */
// Purpose: Types shared by the four pin port files
// Assumes: Nothing beyond the register header
// Notes: Register selector carries a none code for unmapped addresses
package fgp_pkg;

    typedef enum logic [3:0] {
        FGP_REG_PIN_LEVEL,
        FGP_REG_DIRECTION,
        FGP_REG_LATCH,
        FGP_REG_ANALOG,
        FGP_REG_PULLUP,
        FGP_REG_OPEN_DRAIN,
        FGP_REG_SLEW,
        FGP_REG_THRESHOLD,
        FGP_REG_NONE
    } fgp_reg_t;

endpackage

/* File: core/fgp_sync.sv */
// Purpose: Two-stage synchroniser for the pad input levels
// Assumes: Inputs may change at any time relative to the clock
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`include "fgp_regs.svh"

module fgp_sync (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic [2*`FGP_PIN_W-1:0] i_async,
    output logic [2*`FGP_PIN_W-1:0] o_sync
);

    logic [2*`FGP_PIN_W-1:0] meta_r;
    logic [2*`FGP_PIN_W-1:0] sync_r;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule // fgp_sync

/* File: core/fgp_port.sv */
// Purpose: Four pin general purpose port with AHB-Lite register access
// Assumes: Single AHB-Lite slave, hready tied back from o_hreadyout
// Notes: Zero wait states; output latch has no reset and powers up unknown
`timescale 1ns/1ps
`include "fgp_regs.svh"

// Notes on behaviour
// - After reset every pin output comes from its own output latch bit.
// - Analog mode never cuts the digital output driver off.
// - Pin-level reads return live pin levels 3:0; bits 7:4 read zero.
// - Pin-level writes go to latch bits 2:0; bit 3 ignores writes.
// - Direction one means input, driver off; zero drives latch; reset one.
// - Direction bit 3 always reads one; upper bits read zero.
// - Latch bits 2:0 read/write, unknown at power-up; upper bits zero.
// - Analog select one disables digital input buffer; bits reset to one.
// - Pull-up bits 3:0 enable pull-ups, reset to one, upper bits zero.
// - A pin configured as output always has its pull-up turned off.
// - Open-drain one makes outputs sink only; bits reset to zero.
// - Slew bits one limit slew rate, zero give full rate; reset one.
// - Threshold bits pick Schmitt one or TTL zero input; reset one.
// - Pins in analog mode read zero through the pin-level register.
// - Port writes store the modified value into the output latch.
module fgp_port (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic [`FGP_PIN_W-1:0] i_pin_st,
    input wire logic [`FGP_PIN_W-1:0] i_pin_ttl,
    output logic [`FGP_BIDIR_W-1:0] o_pin_out,
    output logic [`FGP_BIDIR_W-1:0] o_pin_oe_n,
    output logic [`FGP_PIN_W-1:0] o_pullup_en,
    output logic [`FGP_BIDIR_W-1:0] o_slew_limit,
    output logic [`FGP_PIN_W-1:0] o_schmitt_sel,
    output logic [`FGP_BIDIR_W-1:0] o_analog_sel
);

    function automatic fgp_pkg::fgp_reg_t decode(input logic [31:0] addr);
        fgp_pkg::fgp_reg_t sel;
        sel = fgp_pkg::FGP_REG_NONE;
        case (addr[7:0])
            `FGP_OFF_PIN_LEVEL: sel = fgp_pkg::FGP_REG_PIN_LEVEL;
            `FGP_OFF_DIRECTION: sel = fgp_pkg::FGP_REG_DIRECTION;
            `FGP_OFF_LATCH: sel = fgp_pkg::FGP_REG_LATCH;
            `FGP_OFF_ANALOG: sel = fgp_pkg::FGP_REG_ANALOG;
            `FGP_OFF_PULLUP: sel = fgp_pkg::FGP_REG_PULLUP;
            `FGP_OFF_OPEN_DRAIN: sel = fgp_pkg::FGP_REG_OPEN_DRAIN;
            `FGP_OFF_SLEW: sel = fgp_pkg::FGP_REG_SLEW;
            `FGP_OFF_THRESHOLD: sel = fgp_pkg::FGP_REG_THRESHOLD;
            default: sel = fgp_pkg::FGP_REG_NONE;
        endcase
        return sel;
    endfunction

    logic [2*`FGP_PIN_W-1:0] pads_sync;
    logic [`FGP_PIN_W-1:0] pin_level;
    logic tx_take;
    fgp_pkg::fgp_reg_t rd_sel;

    logic wr_pend_r, wr_pend_nxt;
    fgp_pkg::fgp_reg_t wr_sel_r, wr_sel_nxt;
    logic [`FGP_BIDIR_W-1:0] dir_r, dir_nxt;
    logic [`FGP_BIDIR_W-1:0] lat_r, lat_nxt;
    logic [`FGP_BIDIR_W-1:0] ansel_r, ansel_nxt;
    logic [`FGP_PIN_W-1:0] wpu_r, wpu_nxt;
    logic [`FGP_BIDIR_W-1:0] od_r, od_nxt;
    logic [`FGP_BIDIR_W-1:0] slr_r, slr_nxt;
    logic [`FGP_PIN_W-1:0] inlvl_r, inlvl_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic [`FGP_BIDIR_W-1:0] pin_out_r, pin_out_nxt;
    logic [`FGP_BIDIR_W-1:0] pin_oe_n_r, pin_oe_n_nxt;
    logic [`FGP_PIN_W-1:0] pullup_r, pullup_nxt;
    logic hreadyout_r;
    logic hresp_r;
    logic lat_seen_r, lat_seen_nxt;

    fgp_sync u_sync (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_async({i_pin_st, i_pin_ttl}),
        .o_sync(pads_sync)
    );

    always_comb begin
        tx_take = i_hsel && i_htrans[1] && i_hready;
        rd_sel = decode(i_haddr);
        wr_pend_nxt = tx_take && i_hwrite;
        wr_sel_nxt = tx_take ? rd_sel : wr_sel_r;
        dir_nxt = dir_r;
        lat_nxt = lat_r;
        ansel_nxt = ansel_r;
        wpu_nxt = wpu_r;
        od_nxt = od_r;
        slr_nxt = slr_r;
        inlvl_nxt = inlvl_r;
        if (wr_pend_r && i_hready) begin
            case (wr_sel_r)
                fgp_pkg::FGP_REG_PIN_LEVEL: begin
                    // Bits 2:0 of the modified port image go to the latch
                    lat_nxt = i_hwdata[`FGP_BIDIR_W-1:0];
                end
                fgp_pkg::FGP_REG_DIRECTION: begin
                    dir_nxt = i_hwdata[`FGP_BIDIR_W-1:0];
                end
                fgp_pkg::FGP_REG_LATCH: begin
                    lat_nxt = i_hwdata[`FGP_BIDIR_W-1:0];
                end
                fgp_pkg::FGP_REG_ANALOG: begin
                    ansel_nxt = i_hwdata[`FGP_BIDIR_W-1:0];
                end
                fgp_pkg::FGP_REG_PULLUP: begin
                    wpu_nxt = i_hwdata[`FGP_PIN_W-1:0];
                end
                fgp_pkg::FGP_REG_OPEN_DRAIN: begin
                    od_nxt = i_hwdata[`FGP_BIDIR_W-1:0];
                end
                fgp_pkg::FGP_REG_SLEW: begin
                    slr_nxt = i_hwdata[`FGP_BIDIR_W-1:0];
                end
                fgp_pkg::FGP_REG_THRESHOLD: begin
                    inlvl_nxt = i_hwdata[`FGP_PIN_W-1:0];
                end
                fgp_pkg::FGP_REG_NONE: begin
                end
            endcase
        end
        // Assertion helper: latch holds a written value since reset
        lat_seen_nxt = lat_seen_r || (wr_pend_r && i_hready
            && (wr_sel_r == fgp_pkg::FGP_REG_PIN_LEVEL
            || wr_sel_r == fgp_pkg::FGP_REG_LATCH));
        // Per-pin threshold choice, then analog pins forced low
        pin_level = (pads_sync[2*`FGP_PIN_W-1:`FGP_PIN_W] & inlvl_nxt)
            | (pads_sync[`FGP_PIN_W-1:0] & ~inlvl_nxt);
        pin_level = pin_level & ~{1'h0, ansel_nxt};
        // Read data forwards a write still in its data phase
        hrdata_nxt = 32'h0;
        if (tx_take && !i_hwrite) begin
            case (rd_sel)
                fgp_pkg::FGP_REG_PIN_LEVEL: begin
                    hrdata_nxt = {28'h0, pin_level};
                end
                fgp_pkg::FGP_REG_DIRECTION: begin
                    hrdata_nxt = {28'h0, `FGP_DIR_BIT3_VALUE, dir_nxt};
                end
                fgp_pkg::FGP_REG_LATCH: begin
                    hrdata_nxt = {29'h0, lat_nxt};
                end
                fgp_pkg::FGP_REG_ANALOG: begin
                    hrdata_nxt = {29'h0, ansel_nxt};
                end
                fgp_pkg::FGP_REG_PULLUP: begin
                    hrdata_nxt = {28'h0, wpu_nxt};
                end
                fgp_pkg::FGP_REG_OPEN_DRAIN: begin
                    hrdata_nxt = {29'h0, od_nxt};
                end
                fgp_pkg::FGP_REG_SLEW: begin
                    hrdata_nxt = {29'h0, slr_nxt};
                end
                fgp_pkg::FGP_REG_THRESHOLD: begin
                    hrdata_nxt = {28'h0, inlvl_nxt};
                end
                fgp_pkg::FGP_REG_NONE: begin
                    hrdata_nxt = 32'h0;
                end
            endcase
        end
        // Driver follows latch, direction and open-drain only; analog select has no say
        pin_oe_n_nxt = dir_nxt | (od_nxt & lat_nxt);
        pin_out_nxt = lat_nxt & ~od_nxt;
        pullup_nxt = {wpu_nxt[`FGP_INPUT_ONLY_BIT],
            wpu_nxt[`FGP_BIDIR_W-1:0] & dir_nxt};
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_pend_r <= 1'h0;
            wr_sel_r <= fgp_pkg::FGP_REG_NONE;
            dir_r <= `FGP_RST_DIRECTION;
            ansel_r <= `FGP_RST_ANALOG;
            wpu_r <= `FGP_RST_PULLUP;
            od_r <= `FGP_RST_OPEN_DRAIN;
            slr_r <= `FGP_RST_SLEW;
            inlvl_r <= `FGP_RST_THRESHOLD;
            hrdata_r <= 32'h0;
            pin_out_r <= 3'h0;
            pin_oe_n_r <= 3'h7;
            pullup_r <= 4'h0;
            hreadyout_r <= 1'h0;
            hresp_r <= 1'h0;
            lat_seen_r <= 1'h0;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_sel_r <= wr_sel_nxt;
            dir_r <= dir_nxt;
            ansel_r <= ansel_nxt;
            wpu_r <= wpu_nxt;
            od_r <= od_nxt;
            slr_r <= slr_nxt;
            inlvl_r <= inlvl_nxt;
            hrdata_r <= hrdata_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_n_r <= pin_oe_n_nxt;
            pullup_r <= pullup_nxt;
            hreadyout_r <= 1'h1;
            lat_seen_r <= lat_seen_nxt;
            hresp_r <= 1'h0;
        end
    end

    // Latch keeps its contents across resets; unknown only at power-up
    always_ff @(posedge i_ref_clk) begin
        lat_r <= lat_nxt;
    end

    assign o_hreadyout = hreadyout_r;
    assign o_hresp = hresp_r;
    assign o_hrdata = hrdata_r;
    assign o_pin_out = pin_out_r;
    assign o_pin_oe_n = pin_oe_n_r;
    assign o_pullup_en = pullup_r;
    assign o_slew_limit = slr_r;
    assign o_schmitt_sel = inlvl_r;
    assign o_analog_sel = ansel_r;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);

    property p_pullup_off_out;
        i_nrst |=> ((o_pullup_en[2:0] & ~dir_r) == 3'h0)
            && (o_pullup_en[3] == wpu_r[3]);
    endproperty
    a_pullup_off_out: assert property (p_pullup_off_out)
        else $error("pull-up on for an output pin");

    property p_analog_reads_zero;
        (tx_take && !i_hwrite && rd_sel == fgp_pkg::FGP_REG_PIN_LEVEL)
            |=> ((o_hrdata[2:0] & ansel_r) == 3'h0);
    endproperty
    a_analog_reads_zero: assert property (p_analog_reads_zero)
        else $error("analog pin read as one");

    property p_port_upper_zero;
        (tx_take && !i_hwrite && rd_sel == fgp_pkg::FGP_REG_PIN_LEVEL)
            |=> (o_hrdata[31:4] == 28'h0);
    endproperty
    a_port_upper_zero: assert property (p_port_upper_zero)
        else $error("pin-level upper bits not zero");

    property p_dir_bit3_one;
        (tx_take && !i_hwrite && rd_sel == fgp_pkg::FGP_REG_DIRECTION)
            |=> (o_hrdata[31:3] == {28'h0, 1'h1}) && (o_hrdata[2:0] == dir_r);
    endproperty
    a_dir_bit3_one: assert property (p_dir_bit3_one)
        else $error("direction read-back wrong");

    property p_port_write_latch;
        (wr_pend_r && i_hready && wr_sel_r == fgp_pkg::FGP_REG_PIN_LEVEL)
            |=> (lat_r == $past(i_hwdata[2:0]))
            ##1 (o_pin_out == (lat_r & ~od_r));
    endproperty
    a_port_write_latch: assert property (p_port_write_latch)
        else $error("port write did not reach latch");

    property p_input_no_drive;
        ##1 (dir_r == 3'h7) |-> (o_pin_oe_n == 3'h7);
    endproperty
    a_input_no_drive: assert property (p_input_no_drive)
        else $error("driver on for an input pin");

    property p_od_no_source;
        ##1 ((o_pin_out & ~o_pin_oe_n & od_r) == 3'h0);
    endproperty
    a_od_no_source: assert property (p_od_no_source)
        else $error("open-drain pin sourcing high");

    property p_analog_keeps_drive;
        ##1 (lat_seen_r && dir_r[0] == 1'h0 && od_r[0] == 1'h0
            && ansel_r[0])
            |-> (!o_pin_oe_n[0] && o_pin_out[0] == lat_r[0]);
    endproperty
    a_analog_keeps_drive: assert property (p_analog_keeps_drive)
        else $error("analog mode cut the output driver");

    property p_out_from_latch;
        ##1 (lat_seen_r && od_r == 3'h0) |-> (o_pin_out == lat_r);
    endproperty
    a_out_from_latch: assert property (p_out_from_latch)
        else $error("pin output not from latch");

    property p_config_outputs;
        ##1 (o_slew_limit == slr_r) && (o_schmitt_sel == inlvl_r)
            && (o_analog_sel == ansel_r);
    endproperty
    a_config_outputs: assert property (p_config_outputs)
        else $error("pad control outputs differ from registers");

    property p_bus_okay;
        i_nrst |=> o_hreadyout && !o_hresp;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus answer not ready or not okay");

    c_port_write: cover property (wr_pend_r
        && wr_sel_r == fgp_pkg::FGP_REG_PIN_LEVEL);
    c_port_read: cover property (tx_take && !i_hwrite
        && rd_sel == fgp_pkg::FGP_REG_PIN_LEVEL && ansel_r != 3'h7);
    c_drive_out: cover property (o_pin_oe_n != 3'h7);
    c_od_release: cover property (od_r[0] && !dir_r[0] && o_pin_oe_n[0]);

endmodule // fgp_port

/* File: test/fgp_board_model.sv */
// Purpose: Board circuitry on the four port pads
// Assumes: Any board driver beats a weak pull-up
// Notes: An undriven pad with no pull-up toggles every cycle
`timescale 1ns/1ps

module fgp_board_model (
    input wire logic i_ref_clk,
    input wire logic [2:0] i_pin_out,
    input wire logic [2:0] i_pin_oe_n,
    input wire logic [3:0] i_pullup_en,
    input wire logic [3:0] i_ext_en,
    input wire logic [3:0] i_ext_val,
    input wire logic [3:0] i_mid,
    output logic [3:0] o_pin_st,
    output logic [3:0] o_pin_ttl
);
    logic flt_r = 1'b0;
    logic [3:0] lvl;
    logic [3:0] oe_n;

    always @(posedge i_ref_clk) begin
        flt_r <= ~flt_r;
    end

    always_comb begin
        oe_n = {1'b1, i_pin_oe_n};
        for (int i = 0; i < 4; i++) begin
            if (oe_n[i] === 1'b0) begin
                lvl[i] = i_pin_out[i % 3];
            end else if (i_ext_en[i]) begin
                lvl[i] = i_ext_val[i];
            end else if (i_pullup_en[i] === 1'b1) begin
                lvl[i] = 1'b1;
            end else begin
                lvl[i] = flt_r;
            end
        end
        // A mid level is low to the Schmitt receiver, high to the TTL one
        o_pin_st = lvl & ~i_mid;
        o_pin_ttl = lvl | i_mid;
    end
endmodule // fgp_board_model

/* File: test/fgp_port_tb.sv */
// Purpose: Self-checking bench for the four pin port
// Assumes: Zero wait state slave, hready fed back from hreadyout
// Notes: Expected results queue up and a monitor pops them in order
`timescale 1ns/1ps
`include "fgp_regs.svh"

module fgp_port_tb;
    typedef struct {
        string nm;
        logic [31:0] exp;
        bit cfg;
    } fgp_note_t;

    logic clk = 1'b0, nrst = 1'b0, hsel = 1'b1, hwrite = 1'b0;
    logic pd = 1'b0, rd_ph = 1'b0, hrdy, hresp;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, pout, poen, slew, ana;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
    logic [3:0] st, ttl, pue, schm, v;
    logic [3:0] ext_en = 4'h0, ext_val = 4'h0, mid = 4'h0;
    logic [7:0] offs[8] = '{`FGP_OFF_PIN_LEVEL, `FGP_OFF_DIRECTION,
        `FGP_OFF_LATCH, `FGP_OFF_ANALOG, `FGP_OFF_PULLUP,
        `FGP_OFF_OPEN_DRAIN, `FGP_OFF_SLEW, `FGP_OFF_THRESHOLD};
    logic [31:0] msk[8] = '{32'h0, 32'h7, 32'h7, 32'h7, 32'hf, 32'h7,
        32'h7, 32'hf};
    logic [3:0] thr[3] = '{4'h0, 4'hf, 4'h5};
    fgp_note_t q[$];
    fgp_note_t n;
    int err_count = 0;
    int checks = 0;

    fgp_port dut (.i_ref_clk(clk), .i_nrst(nrst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
        .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_pin_st(st), .i_pin_ttl(ttl), .o_pin_out(pout),
        .o_pin_oe_n(poen), .o_pullup_en(pue), .o_slew_limit(slew),
        .o_schmitt_sel(schm), .o_analog_sel(ana));

    fgp_board_model board (.i_ref_clk(clk), .i_pin_out(pout),
        .i_pin_oe_n(poen), .i_pullup_en(pue), .i_ext_en(ext_en),
        .i_ext_val(ext_val), .i_mid(mid), .o_pin_st(st), .o_pin_ttl(ttl));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic summarize();
        $display("Counts: %0d checks, %0d mismatches", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask

    // Monitor: read data at the end of each read data phase, pads on demand
    always @(posedge clk) begin
        if ((rd_ph && hrdy === 1'b1) || pd) begin
            n = q.pop_front();
            chk(n.nm, !pd ? hrdata : n.cfg ? {22'h0, ana, schm, slew} :
                {22'h0, pue, poen, pout}, n.exp);
        end
        if (hrdy === 1'b1) begin
            rd_ph <= hsel && htrans[1] && !hwrite;
        end
    end

    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hrdy !== 1'b1 && k < 20);
        if (hrdy !== 1'b1) begin
            err_count++;
            summarize();
        end
    endtask

    task automatic bus(logic w, logic [7:0] a, logic [31:0] d,
                       logic [31:0] e, string nm);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        if (!w) begin
            q.push_back('{nm, e, 1'b0});
        end
        wait_ready();
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus(1'b1, a, d, '0, "");
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
        bus(1'b0, a, '0, e, nm);
    endtask

    task automatic pads(logic [31:0] e, bit c, string nm);
        q.push_back('{nm, e, c});
        pd <= 1'b1;
        @(posedge clk);
        pd <= 1'b0;
    endtask

    task automatic do_reset();
        nrst <= 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    initial begin
        void'($urandom(32'h98ca));
        do_reset();
        rd(offs[1], 32'hf, "dir_rst");
        rd(offs[3], 32'h7, "ana_rst");
        rd(offs[4], 32'hf, "pu_rst");
        rd(offs[5], 32'h0, "od_rst");
        rd(offs[6], 32'h7, "slew_rst");
        rd(offs[7], 32'hf, "thr_rst");
        pads(32'h3ff, 1'b1, "cfg_rst");
        $display("test reset values done");
        for (int j = 0; j < 3; j++) begin
            for (int i = 1; i < 8; i++) begin
                r = (j == 0) ? 32'h0 : $urandom();
                wr(offs[i], r);
                rd(offs[i], (r & msk[i]) | (i == 1 ? 32'h8 : 32'h0),
                   "reg_rw");
            end
        end
        wr(8'h20, 32'hffffffff);
        rd(8'h20, 32'h0, "unmapped");
        $display("test register access done");
        wr(offs[3], 32'h7);
        wr(offs[5], 32'h0);
        wr(offs[4], 32'hf);
        wr(offs[1], 32'h0);
        wr(offs[0], 32'hfd);
        rd(offs[2], 32'h5, "latch_from_pin_wr");
        pads(32'h205, 1'b0, "push_pull");
        wr(offs[5], 32'h7);
        pads(32'h228, 1'b0, "open_drain");
        wr(offs[1], 32'h7);
        pads(32'h3f8, 1'b0, "inputs");
        $display("test pad drive done");
        v = 4'($urandom());
        ext_en <= 4'hf;
        ext_val <= ~v;
        wr(offs[3], 32'h0);
        wr(offs[7], 32'hf);
        ext_val <= v;
        rd(offs[0], {28'h0, ~v}, "pin_sync_old");
        rd(offs[0], {28'h0, v}, "pin_level");
        wr(offs[3], 32'h7);
        rd(offs[0], {28'h0, v & 4'h8}, "pin_analog");
        wr(offs[3], 32'h0);
        mid <= 4'hf;
        for (int i = 0; i < 3; i++) begin
            wr(offs[7], {28'h0, thr[i]});
            rd(offs[0], {28'h0, ~thr[i]}, "pin_threshold");
        end
        $display("test pin reads done");
        wr(offs[2], 32'h6);
        do_reset();
        rd(offs[2], 32'h6, "latch_kept");
        rd(offs[1], 32'hf, "dir_rst2");
        pads(32'h3fe, 1'b0, "pads_rst2");
        $display("test second reset done");
        repeat (2) @(posedge clk);
        summarize();
    end
endmodule // fgp_port_tb
